// ===== logic/smi_sci_event_router.sv
`timescale 1ns/1ps
module smi_sci_event_router (
   input wire logic clk,
   input wire logic reset,
   input wire logic global_mgmt_irq_enable,
   input wire logic control_irq_enable,
   input wire logic sleep_trap_enable,
   input wire event_router_pkg::mgmt_bits_t mgmt_irq_enable_reg,
   input wire logic [15:0] pin_event_route,
   input wire logic [31:0] general_event_enable,
   input wire logic [31:0] pin_mgmt_enable,
   input wire logic [15:0] pin_level,
   input wire event_router_pkg::mgmt_bits_t mgmt_event,
   input wire event_router_pkg::unit_bits_t unit_event,
   input wire event_router_pkg::ctrl_bits_t ctrl_event,
   input wire logic sleep_request_bit,
   input wire logic usb_port_write_ctrl,
   input wire logic host_write_req,
   input wire logic synchronous_irq_ack_msg,
   input wire logic eoh_set,
   input wire event_router_pkg::mgmt_bits_t mgmt_clear,
   input wire event_router_pkg::unit_bits_t unit_clear,
   input wire event_router_pkg::ctrl_bits_t ctrl_clear,
   input wire logic [31:0] general_event_clear,
   input wire logic [31:0] pin_mgmt_clear,
   output event_router_pkg::mgmt_bits_t mgmt_status,
   output event_router_pkg::unit_bits_t unit_status,
   output event_router_pkg::ctrl_bits_t ctrl_status,
   output logic [31:0] general_event_status_reg,
   output logic [31:0] pin_mgmt_event_reg,
   output logic end_of_handler_bit,
   output logic mgmt_irq_msg,
   output logic control_irq,
   output logic soft_off_req,
   output logic host_write_done,
   output logic bridge_sync_ack_msg
);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [15:0] pin_meta;
   logic [15:0] pin_sync;
   logic usb_wr_prev;
   logic sleep_prev;

   // Pins come from outside the clock domain and pass two flops.
   always_ff @(posedge clk) begin
      if (reset) begin
         pin_meta <= 16'h0000;
         pin_sync <= 16'h0000;
      end else begin
         pin_meta <= pin_level;
         pin_sync <= pin_meta;
      end
   end

   // Edge memories for software-written control bits.
   always_ff @(posedge clk) begin
      if (reset) begin
         usb_wr_prev <= 1'b0;
         sleep_prev <= 1'b0;
      end else begin
         usb_wr_prev <= usb_port_write_ctrl;
         sleep_prev <= sleep_request_bit;
      end
   end

   // ----------------------------------------------------------------
   // Event decode
   // ----------------------------------------------------------------
   function automatic logic [7:0] route_match(input logic [15:0] route, input logic [1:0] code);
      logic [7:0] hit;
      hit = 8'h00;
      for (int i = 0; i < event_router_pkg::PIN_COUNT; i++) begin
         hit[i] = (route[2*i +: 2] == code);
      end
      return hit;
   endfunction

   function automatic logic [31:0] set_or_clear(input logic [31:0] cur, input logic [31:0] set,
                                                input logic [31:0] clr);
      return set | (cur & ~clr);
   endfunction

   logic [7:0] to_ctrl;
   logic [7:0] to_mgmt;
   logic [31:0] next_gpe_set;
   logic [31:0] next_alt_set;
   event_router_pkg::mgmt_bits_t mgmt_hit;
   logic sleep_write;
   logic usb_rise;

   assign to_ctrl = route_match(pin_event_route, event_router_pkg::ROUTE_CTRL);
   assign to_mgmt = route_match(pin_event_route, event_router_pkg::ROUTE_MGMT);
   assign sleep_write = sleep_request_bit && !sleep_prev;
   assign usb_rise = usb_port_write_ctrl && !usb_wr_prev;

   // Pin status words are built from route and enable criteria.
   always_comb begin
      next_gpe_set = event_router_pkg::WORD_ZERO;
      next_alt_set = event_router_pkg::WORD_ZERO;
      next_gpe_set[event_router_pkg::CORE_CTRL_LSB +: 8] = pin_sync[15:8] & to_ctrl
         & general_event_enable[event_router_pkg::CORE_CTRL_LSB +: 8];
      next_gpe_set[event_router_pkg::SUS_CTRL_LSB +: 8] = pin_sync[7:0] & to_ctrl
         & general_event_enable[event_router_pkg::SUS_CTRL_LSB +: 8];
      next_alt_set[event_router_pkg::CORE_CTRL_LSB +: 8] = pin_sync[15:8] & to_mgmt
         & pin_mgmt_enable[event_router_pkg::CORE_MGMT_EN_LSB +: 8];
      next_alt_set[event_router_pkg::SUS_CTRL_LSB +: 8] = pin_sync[7:0] & to_mgmt
         & pin_mgmt_enable[event_router_pkg::SUS_MGMT_EN_LSB +: 8];
   end

   // Management-only events, with the special sleep and USB causes merged in.
   always_comb begin
      mgmt_hit = mgmt_event;
      mgmt_hit.sleep_trap = sleep_write && sleep_trap_enable;
      mgmt_hit.port_write = usb_rise && mgmt_irq_enable_reg.port_write;
      mgmt_hit.usb_is = mgmt_event.usb_is || mgmt_hit.port_write;
   end

   // ----------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------
   // Sticky status flags.
   always_ff @(posedge clk) begin
      if (reset) begin
         mgmt_status <= '0;
         unit_status <= '0;
         ctrl_status <= '0;
      end else begin
         mgmt_status <= mgmt_hit | (mgmt_status & ~mgmt_clear);
         unit_status <= unit_event | (unit_status & ~unit_clear);
         ctrl_status <= ctrl_event | (ctrl_status & ~ctrl_clear);
      end
   end

   // Pin status words; a set in the clearing cycle wins.
   always_ff @(posedge clk) begin
      if (reset) begin
         general_event_status_reg <= event_router_pkg::WORD_ZERO;
         pin_mgmt_event_reg <= event_router_pkg::WORD_ZERO;
      end else begin
         general_event_status_reg <= set_or_clear(general_event_status_reg, next_gpe_set,
                                                  general_event_clear);
         pin_mgmt_event_reg <= set_or_clear(pin_mgmt_event_reg, next_alt_set, pin_mgmt_clear);
      end
   end

   // ----------------------------------------------------------------
   // Interrupt decisions
   // ----------------------------------------------------------------
   logic mgmt_pending;
   logic ctrl_pending;
   logic sync_cause;

   always_comb begin
      // Unit sources need no local enable.
      // Bridge under global enable.
      // The sleep trap is armed by its own trap enable, so a latched trap asks whenever the global enable is set;
      // otherwise a held host write would wait for a message that never leaves.
      mgmt_pending = global_mgmt_irq_enable && (
         |(mgmt_status & mgmt_irq_enable_reg) || mgmt_status.sleep_trap ||
         unit_status.gfx_mgmt || unit_status.flash_mgmt || unit_status.bridge_mgmt ||
         unit_status.bridge_sync || |pin_mgmt_event_reg);
      ctrl_pending = ctrl_status.global_release || (control_irq_enable && (
         ctrl_status.button_override || unit_status.gfx_ctrl ||
         |general_event_status_reg));
   end

   assign sync_cause = global_mgmt_irq_enable && (mgmt_hit.sleep_trap || mgmt_hit.port_write
      || (mgmt_hit.bios_release && mgmt_irq_enable_reg.bios_release));

   always_ff @(posedge clk) begin
      if (reset) begin
         end_of_handler_bit <= 1'b1;
         mgmt_irq_msg <= 1'b0;
      end else begin
         mgmt_irq_msg <= mgmt_pending && end_of_handler_bit && !eoh_set;
         if (mgmt_pending && end_of_handler_bit && !eoh_set) begin
            end_of_handler_bit <= 1'b0;
         end else if (eoh_set) begin
            end_of_handler_bit <= 1'b1;
         end
      end
   end

   // Control line level.
   always_ff @(posedge clk) begin
      if (reset) begin
         control_irq <= 1'b0;
      end else begin
         control_irq <= ctrl_pending;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         soft_off_req <= 1'b0;
      end else begin
         soft_off_req <= ctrl_event.button_override;
      end
   end

   // ----------------------------------------------------------------
   // Synchronous completion holding
   // ----------------------------------------------------------------
   event_router_pkg::sync_state_t sync_state;
   logic held_host;
   logic held_bridge;

   always_ff @(posedge clk) begin
      if (reset) begin
         sync_state <= event_router_pkg::SYNC_IDLE;
         held_host <= 1'b0;
         held_bridge <= 1'b0;
         host_write_done <= 1'b0;
         bridge_sync_ack_msg <= 1'b0;
      end else begin
         host_write_done <= 1'b0;
         bridge_sync_ack_msg <= 1'b0;
         unique case (sync_state)
            event_router_pkg::SYNC_IDLE: begin
               if (unit_event.bridge_sync && global_mgmt_irq_enable) begin
                  held_bridge <= 1'b1;
                  held_host <= 1'b0;
                  sync_state <= event_router_pkg::SYNC_WAIT;
               end else if (host_write_req && sync_cause) begin
                  held_host <= 1'b1;
                  held_bridge <= 1'b0;
                  sync_state <= event_router_pkg::SYNC_WAIT;
               end else if (host_write_req) begin
                  host_write_done <= 1'b1;
               end else if (unit_event.bridge_sync) begin
                  bridge_sync_ack_msg <= 1'b1;
               end
            end
            event_router_pkg::SYNC_WAIT: begin
               if (synchronous_irq_ack_msg) begin
                  sync_state <= event_router_pkg::SYNC_DONE;
               end
            end
            event_router_pkg::SYNC_DONE: begin
               host_write_done <= held_host;
               bridge_sync_ack_msg <= held_bridge;
               sync_state <= event_router_pkg::SYNC_IDLE;
            end
            default: begin
               sync_state <= event_router_pkg::SYNC_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   release_ctrl_a: assert property (@(posedge clk) disable iff (reset)
      ctrl_status.global_release |=> control_irq)
      else $error("Release flag did not raise control interrupt.");

   override_off_a: assert property (@(posedge clk) disable iff (reset)
      ctrl_event.button_override |=> soft_off_req)
      else $error("Override did not request soft-off.");

   single_msg_a: assert property (@(posedge clk) disable iff (reset)
      mgmt_irq_msg |-> !end_of_handler_bit)
      else $error("Message sent while end-of-handler still set.");

   no_global_a: assert property (@(posedge clk) disable iff (reset)
      !$past(global_mgmt_irq_enable) |-> !mgmt_irq_msg)
      else $error("Management message without global enable.");

   host_hold_a: assert property (@(posedge clk) disable iff (reset)
      (sync_state == event_router_pkg::SYNC_WAIT) |-> !host_write_done)
      else $error("Host completion released before acknowledge.");

   bridge_hold_a: assert property (@(posedge clk) disable iff (reset)
      (sync_state == event_router_pkg::SYNC_WAIT) && synchronous_irq_ack_msg && held_bridge
      |=> ##1 bridge_sync_ack_msg)
      else $error("Bridge acknowledge not sent after sync acknowledge.");

   sleep_trap_a: assert property (@(posedge clk) disable iff (reset)
      sleep_write && sleep_trap_enable |=> mgmt_status.sleep_trap)
      else $error("Sleep trap status not latched.");

   usb_rise_a: assert property (@(posedge clk) disable iff (reset)
      usb_rise && mgmt_irq_enable_reg.port_write |=> mgmt_status.port_write && mgmt_status.usb_is)
      else $error("Port write rise did not set both USB flags.");

   status_sticky_a: assert property (@(posedge clk) disable iff (reset)
      mgmt_event.periodic |=> mgmt_status.periodic)
      else $error("Periodic status not latched.");

   pin_gate_a: assert property (@(posedge clk) disable iff (reset)
      !(|to_ctrl) && !(|general_event_status_reg) |=> !(|general_event_status_reg))
      else $error("Pin control flag set without route.");

   sync_cover_c: cover property (@(posedge clk) sync_state == event_router_pkg::SYNC_DONE);
   msg_cover_c: cover property (@(posedge clk) mgmt_irq_msg);
   ctrl_cover_c: cover property (@(posedge clk) control_irq && !control_irq_enable);

endmodule

// ===== logic/event_router_pkg.sv
package event_router_pkg;

   // ----------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------
   localparam int unsigned PIN_COUNT = 8;
   localparam logic [1:0] ROUTE_MGMT = 2'h1;
   localparam logic [1:0] ROUTE_CTRL = 2'h2;
   localparam int unsigned CORE_CTRL_LSB = 24;
   localparam int unsigned SUS_CTRL_LSB = 16;
   localparam int unsigned CORE_MGMT_EN_LSB = 8;
   localparam int unsigned SUS_MGMT_EN_LSB = 0;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // Management-only sources with a local enable.
   typedef struct packed {
      logic usb_is;
      logic usb;
      logic periodic;
      logic watchdog;
      logic sw_timer;
      logic sleep_trap;
      logic bios_release;
      logic port_write;
   } mgmt_bits_t;

   // Sources enabled by their own unit, with no local enable.
   typedef struct packed {
      logic gfx_ctrl;
      logic gfx_mgmt;
      logic flash_mgmt;
      logic bridge_mgmt;
      logic bridge_sync;
   } unit_bits_t;

   // Fixed control events.
   typedef struct packed {
      logic button_override;
      logic global_release;
   } ctrl_bits_t;

   typedef enum logic [2:0] {
      SYNC_IDLE = 3'h1,
      SYNC_WAIT = 3'h2,
      SYNC_DONE = 3'h4
   } sync_state_t;

endpackage

// ===== verif/core_msg_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Core messaging unit stand-in
// ------------------------------------------------------------
// Answers each management message with a synchronous acknowledge.
// The core cannot tell a synchronous message from a plain one, so it
// acknowledges every message; the router ignores acks while idle.
module core_msg_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic mgmt_irq_msg,
   input wire logic [7:0] ack_delay,
   output logic synchronous_irq_ack_msg
);
   logic [7:0] wait_count;
   always_ff @(posedge clk) begin
      if (reset) begin
         wait_count <= 8'h00;
         synchronous_irq_ack_msg <= 1'b0;
      end else begin
         synchronous_irq_ack_msg <= (wait_count == 8'h01);
         if (mgmt_irq_msg) begin
            wait_count <= ack_delay;
         end else if (wait_count != 8'h00) begin
            wait_count <= wait_count - 8'h01;
         end
      end
   end
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic global_mgmt_irq_enable, control_irq_enable, sleep_trap_enable;
   logic sleep_request_bit, usb_port_write_ctrl, host_write_req, eoh_set;
   logic synchronous_irq_ack_msg, end_of_handler_bit, mgmt_irq_msg, control_irq;
   logic soft_off_req, host_write_done, bridge_sync_ack_msg;
   logic [15:0] pin_event_route, pin_level;
   logic [31:0] general_event_enable, pin_mgmt_enable, general_event_clear;
   logic [31:0] pin_mgmt_clear, general_event_status_reg, pin_mgmt_event_reg;
   event_router_pkg::mgmt_bits_t mgmt_irq_enable_reg, mgmt_event, mgmt_clear, mgmt_status;
   event_router_pkg::unit_bits_t unit_event, unit_clear, unit_status;
   event_router_pkg::ctrl_bits_t ctrl_event, ctrl_clear, ctrl_status;
   logic [7:0] ack_delay;
   int fail_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int msgs = 0;
   int base = 0;
   int ack_cyc = 0;
   int done_cyc = 0;

   smi_sci_event_router smi_sci_event_router_inst (.clk, .reset, .global_mgmt_irq_enable,
      .control_irq_enable, .sleep_trap_enable, .mgmt_irq_enable_reg, .pin_event_route,
      .general_event_enable, .pin_mgmt_enable, .pin_level, .mgmt_event, .unit_event,
      .ctrl_event, .sleep_request_bit, .usb_port_write_ctrl, .host_write_req,
      .synchronous_irq_ack_msg, .eoh_set, .mgmt_clear, .unit_clear, .ctrl_clear,
      .general_event_clear, .pin_mgmt_clear, .mgmt_status, .unit_status, .ctrl_status,
      .general_event_status_reg, .pin_mgmt_event_reg, .end_of_handler_bit, .mgmt_irq_msg,
      .control_irq, .soft_off_req, .host_write_done, .bridge_sync_ack_msg);
   core_msg_model core_msg_model_inst (.clk, .reset, .mgmt_irq_msg, .ack_delay,
      .synchronous_irq_ack_msg);

   // The clock toggles every half period of 4 ns.
   always #4 clk = ~clk;

   // Counts cycles and messages, and stamps acks and completions.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (mgmt_irq_msg === 1'b1) msgs <= msgs + 1;
      if (synchronous_irq_ack_msg === 1'b1) ack_cyc <= cyc;
      if (host_write_done === 1'b1 || bridge_sync_ack_msg === 1'b1) done_cyc <= cyc;
   end

   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic look(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Pulses event inputs for one cycle; returns at the edge that samples them.
   task automatic fire(input logic [7:0] m, input logic [4:0] u, input logic [1:0] c);
      tick(1);
      mgmt_event <= m;
      unit_event <= u;
      ctrl_event <= c;
      tick(1);
      mgmt_event <= '0;
      unit_event <= '0;
      ctrl_event <= '0;
   endtask
   // Clears every flag, then re-arms the handler bit.
   task automatic tidy();
      tick(1);
      {mgmt_clear, unit_clear, ctrl_clear} <= '1;
      {general_event_clear, pin_mgmt_clear} <= '1;
      tick(1);
      {mgmt_clear, unit_clear, ctrl_clear} <= '0;
      {general_event_clear, pin_mgmt_clear} <= '0;
      eoh_set <= 1'b1;
      tick(1);
      eoh_set <= 1'b0;
      tick(2);
      base = msgs;
   endtask
   // Waits a bounded time for a held completion to come out.
   task automatic wait_done();
      int d0;
      d0 = done_cyc;
      for (int k = 0; k < 60 && done_cyc == d0; k++) look(1);
      // A completion that never comes counts as a mismatch.
      chk(done_cyc != d0, 1);
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Watchdog against a hang.
   initial begin
      #(8 * 4000);
      fail_count++;
      print_verdict();
   end

   // Main sequence.
   initial begin
      {global_mgmt_irq_enable, control_irq_enable, sleep_trap_enable} = '0;
      {sleep_request_bit, usb_port_write_ctrl, host_write_req, eoh_set} = '0;
      {mgmt_irq_enable_reg, mgmt_event, mgmt_clear, unit_event, unit_clear} = '0;
      {ctrl_event, ctrl_clear, pin_event_route, pin_level} = '0;
      {general_event_enable, pin_mgmt_enable, general_event_clear, pin_mgmt_clear} = '0;
      ack_delay = 8'h06;
      tick(16);
      reset <= 1'b0;
      look(1);
      chk({mgmt_status, unit_status, ctrl_status, end_of_handler_bit}, 32'h1);
      tick(1);
      global_mgmt_irq_enable <= 1'b1;
      fire(8'h10, 5'h00, 2'h0);
      look(1);
      chk(mgmt_status, 8'h10);
      look(3);
      chk(msgs - base, 0);
      tidy();
      mgmt_irq_enable_reg <= 8'h20;
      fire(8'h20, 5'h00, 2'h0);
      look(2);
      chk({mgmt_irq_msg, end_of_handler_bit}, 32'h2);
      look(3);
      chk(msgs - base, 1);
      tick(1);
      eoh_set <= 1'b1;
      tick(1);
      eoh_set <= 1'b0;
      look(3);
      chk(msgs - base, 2);
      tidy();
      global_mgmt_irq_enable <= 1'b0;
      fire(8'h20, 5'h06, 2'h0);
      look(1);
      chk(unit_status, 5'h06);
      look(3);
      chk(msgs - base, 0);
      tick(1);
      global_mgmt_irq_enable <= 1'b1;
      look(4);
      chk(msgs - base, 1);
      tidy();
      fire(8'h00, 5'h00, 2'h2);
      look(1);
      chk({soft_off_req, ctrl_status}, 32'h6);
      look(3);
      chk(msgs - base, 0);
      chk(control_irq, 0);
      tick(1);
      control_irq_enable <= 1'b1;
      look(8);
      chk(control_irq, 1);
      tick(1);
      ctrl_clear <= 2'h2;
      tick(1);
      ctrl_clear <= 2'h0;
      look(3);
      chk(control_irq, 0);
      tick(1);
      control_irq_enable <= 1'b0;
      fire(8'h00, 5'h00, 2'h1);
      look(3);
      chk(control_irq, 1);
      tidy();
      pin_event_route <= 16'h800a;
      general_event_enable <= 32'h8001_0000;
      pin_mgmt_enable <= '1;
      pin_level <= 16'h8003;
      look(8);
      chk(general_event_status_reg, 32'h8001_0000);
      chk(pin_mgmt_event_reg, 0);
      tick(1);
      pin_event_route <= 16'h4005;
      general_event_enable <= '1;
      pin_mgmt_enable <= 32'h0000_8001;
      tidy();
      look(6);
      chk(pin_mgmt_event_reg, 32'h8001_0000);
      chk(general_event_status_reg, 0);
      tick(1);
      pin_level <= 16'h0000;
      tick(4);
      tidy();
      sleep_trap_enable <= 1'b1;
      mgmt_irq_enable_reg <= 8'h04;
      host_write_req <= 1'b1;
      sleep_request_bit <= 1'b1;
      tick(1);
      host_write_req <= 1'b0;
      wait_done();
      chk(mgmt_status, 8'h04);
      chk(done_cyc - ack_cyc, 2);
      chk(msgs - base, 1);
      tidy();
      global_mgmt_irq_enable <= 1'b0;
      sleep_request_bit <= 1'b0;
      tick(1);
      host_write_req <= 1'b1;
      sleep_request_bit <= 1'b1;
      tick(1);
      host_write_req <= 1'b0;
      look(1);
      chk({host_write_done, mgmt_status}, 32'h104);
      look(3);
      chk(msgs - base, 0);
      tidy();
      global_mgmt_irq_enable <= 1'b1;
      ack_delay <= 8'h01;
      fire(8'h00, 5'h01, 2'h0);
      wait_done();
      chk(done_cyc - ack_cyc, 2);
      tidy();
      mgmt_irq_enable_reg <= 8'h81;
      usb_port_write_ctrl <= 1'b1;
      host_write_req <= 1'b1;
      tick(1);
      host_write_req <= 1'b0;
      wait_done();
      chk(mgmt_status & 8'h81, 8'h81);
      chk(done_cyc - ack_cyc, 2);
      tidy();
      print_verdict();
   end
endmodule
